// [scl_pkg.sv]
/*
  Shared definitions for the synthesizer calibration and lock control block:
  APB register offsets, field positions, reset values, timing constants,
  and the packed carrier structs.
  Assumes a 32-bit APB bus and a single 100 MHz pclk domain.
*/
package scl_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFF_REG_ZERO = 8'h00; // register zero: cal enable, sleep, order
  localparam logic [7:0] OFF_CFG = 8'h04; // lock detect and sensor configuration
  localparam logic [7:0] OFF_OUT = 8'h08; // output source and divider taps
  localparam logic [7:0] OFF_SEED = 8'h0C; // modulator seed
  localparam logic [7:0] OFF_STATUS = 8'h10; // lock and cal state, read only
  localparam logic [7:0] OFF_CALRES = 8'h14; // calibration results, read only
  localparam logic [7:0] OFF_TEMP = 8'h18; // temperature code, read only
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1C; // sticky events, write one to clear
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20; // interrupt mask

  // register zero fields
  localparam int R0_CAL_EN_BIT = 0;
  localparam int R0_SLEEP_BIT = 1;
  localparam int R0_ORDER_LSB = 2;
  // cfg fields
  localparam int CFG_TUNE_CHK_BIT = 0;
  localparam int CFG_TEMP_EN_BIT = 1;
  localparam int CFG_BYPASS_BIT = 2;
  localparam int CFG_DLY_LSB = 8;
  // output fields
  localparam int OUT_SRC_A_LSB = 0;
  localparam int OUT_SRC_B_LSB = 2;
  localparam int OUT_DIV_A_LSB = 4;
  localparam int OUT_DIV_B_LSB = 8;

  // field values
  localparam logic [1:0] SRC_DOUBLER = 2'h2; // output takes the doubled oscillator
  localparam logic [2:0] DIV_LOG_MIN = 3'h1; // divide by 2
  localparam logic [2:0] DIV_LOG_MAX = 3'h7; // divide by 128
  localparam logic [1:0] ORDER_INTEGER = 2'h0;
  localparam logic [17:0] LOCK_DLY_MULT = 18'h00004; // delay counted in 4 pd cycles

  // interrupt event bits
  localparam int EV_CAL_DONE = 0;
  localparam int EV_LOCK_LOST = 1;
  localparam int EV_DIV_FIXUP = 2;
  localparam int EV_W = 3;

  // reset values
  localparam logic [31:0] RST_REG_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_OUT = 32'h0000_0011;

  // calibration phases
  typedef enum logic [2:0] {
    SCL_IDLE, SCL_FREQ, SCL_AMP, SCL_FILT, SCL_DELAY
  } scl_phase_t;

  // results handed back by the analog calibration engines
  typedef struct packed {
    logic [2:0] core;
    logic [7:0] cap_code;
    logic [7:0] amp_code;
  } scl_cal_res_t;

  // controls steering the analog section
  typedef struct packed {
    logic sleep;
    logic [1:0] modulator_order;
    logic [31:0] modulator_seed;
    logic seed_apply;
    logic [1:0] src_a;
    logic [1:0] src_b;
    logic [2:0] div_log_a;
    logic [2:0] div_log_b;
    logic doubler_a;
    logic doubler_b;
  } scl_ctrl_t;

endpackage : scl_pkg

// [scl_sync.sv]
/*
  Three-stage synchroniser with agreement filter for asynchronous pins.
  Assumes pclk domain; the output changes only when stages two and three agree.
*/
`timescale 1ns/1ps
module scl_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin side
  input wire logic pin_in,
  // synchronised level
  output logic level_out
);

  // stage 0 is only read by stage 1
  typedef struct packed {
    logic [2:0] stg;
    logic level;
  } scl_sync_st_t;

  scl_sync_st_t st_reg;
  scl_sync_st_t st_next;

  // shift and accept a change once the last two stages agree
  always_comb begin
    st_next = st_reg;
    st_next.stg = {st_reg.stg[1:0], pin_in};
    if (st_reg.stg[2] == st_reg.stg[1]) begin
      st_next.level = st_reg.stg[2];
    end
  end

  // register the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= {{3{RST_VAL}}, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level;

endmodule : scl_sync

// [scl_ctrl.sv]
/*
  Calibration, lock detect and status control of a wideband synthesizer.
  Holds the APB register file, sequences frequency, amplitude and filter
  calibration on register zero writes with cal enable set, builds the lock pin and interrupt.
  Assumes the analog engines return done pulses in pclk domain and that
  chip enable and the tuning-voltage comparator are asynchronous pins.
*/
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
module scl_ctrl #(
  parameter int DLY_W = 16 // width of the lock indicate delay field
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic chip_enable_pin,
  input wire logic tune_in_range_pin,
  input wire logic pd_tick,
  output logic lock_pin,
  output logic irq,
  // analog engines
  input wire logic freq_cal_done,
  input wire logic amp_cal_done,
  input wire logic filt_cal_done,
  input wire scl_pkg::scl_cal_res_t cal_res,
  input wire logic [10:0] temperature_code,
  output logic freq_cal_start,
  output logic amp_cal_start,
  output logic filt_cal_start,
  output logic temp_sensor_enable,
  output scl_pkg::scl_ctrl_t ctrl
);

  // every piece of state in one struct
  typedef struct packed {
    logic [31:0] r0;
    logic [31:0] cfg;
    logic [31:0] outsel;
    logic [31:0] seed;
    logic [scl_pkg::EV_W-1:0] ev;
    logic [scl_pkg::EV_W-1:0] mask;
    scl_pkg::scl_phase_t phase;
    logic [DLY_W+1:0] dly_cnt;
    logic cal_ok;
    logic lock;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fstart;
    logic astart;
    logic tstart;
    logic pend_amp;
    scl_pkg::scl_ctrl_t ctrl;
  } scl_st_t;

  scl_st_t st_reg;
  scl_st_t st_next;
  logic ce_sync;
  logic tune_ok_sync;

  // chip enable crosses from a pin
  scl_sync #(.RST_VAL(1'b0)) u_ce_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(chip_enable_pin),
    .level_out(ce_sync)
  );

  // tuning replica comparator crosses from the analog side
  scl_sync #(.RST_VAL(1'b0)) u_tune_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(tune_in_range_pin),
    .level_out(tune_ok_sync)
  );

  // clamp a divider tap to the legal power-of-two range
  function automatic logic [2:0] clamp_div(input logic [2:0] v);
    if (v < scl_pkg::DIV_LOG_MIN) begin
      return scl_pkg::DIV_LOG_MIN;
    end
    return v; // 3-bit field cannot pass 128
  endfunction : clamp_div

  // decode of a readable address
  function automatic logic addr_known(input logic [7:0] a);
    return a inside {scl_pkg::OFF_REG_ZERO, scl_pkg::OFF_CFG, scl_pkg::OFF_OUT,
                     scl_pkg::OFF_SEED, scl_pkg::OFF_STATUS, scl_pkg::OFF_CALRES,
                     scl_pkg::OFF_TEMP, scl_pkg::OFF_IRQ_STAT, scl_pkg::OFF_IRQ_MASK};
  endfunction : addr_known

  // next-state logic: bus, sequencer, lock, interrupt, outputs
  always_comb begin
    logic acc;
    logic wr;
    logic r0_wr;
    logic [scl_pkg::EV_W-1:0] ev_set;
    logic [scl_pkg::EV_W-1:0] ev_clr;
    logic bypass;
    logic tune_chk;
    logic [DLY_W-1:0] dly;
    logic [2:0] da;
    logic [2:0] db;
    logic fixup;
    logic lock_n;
    acc = 1'b0;
    wr = 1'b0;
    r0_wr = 1'b0;
    ev_set = '0;
    ev_clr = '0;
    bypass = 1'b0;
    tune_chk = 1'b0;
    dly = '0;
    da = '0;
    db = '0;
    fixup = 1'b0;
    lock_n = 1'b0;
    st_next = st_reg;
    st_next.fstart = 1'b0;
    st_next.astart = 1'b0;
    st_next.tstart = 1'b0;

    // apb: answer one cycle after the access phase begins
    acc = psel && penable && !st_reg.pready;
    wr = acc && pwrite;
    st_next.pready = acc;
    st_next.pslverr = acc && !addr_known(paddr);
    if (acc && !pwrite) begin
      unique case (paddr)
        scl_pkg::OFF_REG_ZERO: st_next.prdata = st_reg.r0;
        scl_pkg::OFF_CFG: st_next.prdata = st_reg.cfg;
        scl_pkg::OFF_OUT: st_next.prdata = st_reg.outsel;
        scl_pkg::OFF_SEED: st_next.prdata = st_reg.seed;
        scl_pkg::OFF_STATUS: st_next.prdata = {26'h0000000, st_reg.phase,
                                               st_reg.ctrl.sleep, tune_ok_sync,
                                               st_reg.lock};
        scl_pkg::OFF_CALRES: st_next.prdata = {13'h0000, cal_res};
        scl_pkg::OFF_TEMP: st_next.prdata = st_reg.cfg[scl_pkg::CFG_TEMP_EN_BIT] ?
                                            {21'h000000, temperature_code} :
                                            32'h0000_0000;
        scl_pkg::OFF_IRQ_STAT: st_next.prdata = {29'h00000000, st_reg.ev};
        scl_pkg::OFF_IRQ_MASK: st_next.prdata = {29'h00000000, st_reg.mask};
        default: st_next.prdata = 32'h0000_0000;
      endcase
    end

    // writes are taken even while asleep
    if (wr) begin
      unique case (paddr)
        scl_pkg::OFF_REG_ZERO: begin
          st_next.r0 = pwdata;
          r0_wr = 1'b1;
        end
        scl_pkg::OFF_CFG: st_next.cfg = pwdata;
        scl_pkg::OFF_OUT: st_next.outsel = pwdata;
        scl_pkg::OFF_SEED: st_next.seed = pwdata;
        scl_pkg::OFF_IRQ_STAT: ev_clr = pwdata[scl_pkg::EV_W-1:0];
        scl_pkg::OFF_IRQ_MASK: st_next.mask = pwdata[scl_pkg::EV_W-1:0];
        default: ;
      endcase
    end

    bypass = st_reg.cfg[scl_pkg::CFG_BYPASS_BIT];
    tune_chk = st_reg.cfg[scl_pkg::CFG_TUNE_CHK_BIT];
    dly = st_reg.cfg[scl_pkg::CFG_DLY_LSB +: DLY_W];

    // calibration sequencer: frequency, amplitude, filter, delay
    unique case (st_reg.phase)
      scl_pkg::SCL_IDLE: begin
        if (st_reg.pend_amp) begin
          st_next.astart = 1'b1;
          st_next.pend_amp = 1'b0;
        end
      end
      scl_pkg::SCL_FREQ: begin
        if (freq_cal_done) begin
          st_next.phase = scl_pkg::SCL_AMP;
          st_next.astart = 1'b1;
        end
      end
      scl_pkg::SCL_AMP: begin
        if (amp_cal_done) begin
          st_next.phase = scl_pkg::SCL_FILT;
          st_next.tstart = 1'b1;
        end
      end
      scl_pkg::SCL_FILT: begin
        if (filt_cal_done) begin
          st_next.phase = scl_pkg::SCL_DELAY;
          st_next.dly_cnt = tune_chk ?
            (DLY_W+2)'(scl_pkg::LOCK_DLY_MULT * dly) : '0;
        end
      end
      scl_pkg::SCL_DELAY: begin
        if (st_reg.dly_cnt == '0) begin
          st_next.phase = scl_pkg::SCL_IDLE;
          st_next.cal_ok = 1'b1;
          ev_set[scl_pkg::EV_CAL_DONE] = 1'b1;
        end else if (pd_tick) begin
          st_next.dly_cnt = st_reg.dly_cnt - 1'b1;
        end
      end
      // unused phase codes fall back to idle rather than hang
      default: st_next.phase = scl_pkg::SCL_IDLE;
    endcase

    // a register zero write with cal enable set restarts calibration from the top
    if (r0_wr) begin
      if (pwdata[scl_pkg::R0_CAL_EN_BIT]) begin
        st_next.phase = scl_pkg::SCL_FREQ;
        st_next.fstart = 1'b1;
        st_next.cal_ok = 1'b0;
        st_next.pend_amp = 1'b0;
      end else if (st_reg.phase == scl_pkg::SCL_IDLE) begin
        st_next.astart = 1'b1;
      end else begin
        st_next.pend_amp = 1'b1; // run after the running sequence
      end
    end

    // lock: calibration status combined with tuning range
    if (bypass) begin
      lock_n = tune_ok_sync;
    end else begin
      lock_n = st_next.cal_ok && (!tune_chk || tune_ok_sync);
    end
    if (st_reg.ctrl.sleep) begin
      lock_n = 1'b0;
    end
    st_next.lock = lock_n;
    ev_set[scl_pkg::EV_LOCK_LOST] = st_reg.lock && !lock_n;

    // shared divider: 128 on one side drags the other to 128 as well
    da = clamp_div(st_reg.outsel[scl_pkg::OUT_DIV_A_LSB +: 3]);
    db = clamp_div(st_reg.outsel[scl_pkg::OUT_DIV_B_LSB +: 3]);
    if (da == scl_pkg::DIV_LOG_MAX && db != scl_pkg::DIV_LOG_MAX) begin
      db = scl_pkg::DIV_LOG_MAX;
      fixup = 1'b1;
    end else if (db == scl_pkg::DIV_LOG_MAX && da != scl_pkg::DIV_LOG_MAX) begin
      da = scl_pkg::DIV_LOG_MAX;
      fixup = 1'b1;
    end
    // level event: while the clash persists a clear cannot win over it
    ev_set[scl_pkg::EV_DIV_FIXUP] = fixup;

    // analog controls
    st_next.ctrl.sleep = !ce_sync || st_reg.r0[scl_pkg::R0_SLEEP_BIT];
    st_next.ctrl.modulator_order = st_reg.r0[scl_pkg::R0_ORDER_LSB +: 2];
    st_next.ctrl.modulator_seed = st_reg.seed;
    st_next.ctrl.seed_apply = st_next.ctrl.modulator_order != scl_pkg::ORDER_INTEGER;
    st_next.ctrl.src_a = st_reg.outsel[scl_pkg::OUT_SRC_A_LSB +: 2];
    st_next.ctrl.src_b = st_reg.outsel[scl_pkg::OUT_SRC_B_LSB +: 2];
    st_next.ctrl.doubler_a = st_next.ctrl.src_a == scl_pkg::SRC_DOUBLER;
    st_next.ctrl.doubler_b = st_next.ctrl.src_b == scl_pkg::SRC_DOUBLER;
    st_next.ctrl.div_log_a = da;
    st_next.ctrl.div_log_b = db;

    // sticky events: a set in the same cycle as its clear wins
    st_next.ev = (st_reg.ev & ~ev_clr) | ev_set;
    st_next.irq = |(st_next.ev & st_next.mask);
  end

  // the whole state is registered here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.r0 <= scl_pkg::RST_REG_ZERO;
      st_reg.cfg <= scl_pkg::RST_CFG;
      st_reg.outsel <= scl_pkg::RST_OUT;
      st_reg.phase <= scl_pkg::SCL_IDLE;
      st_reg.ctrl.sleep <= 1'b1;
      st_reg.ctrl.div_log_a <= scl_pkg::DIV_LOG_MIN;
      st_reg.ctrl.div_log_b <= scl_pkg::DIV_LOG_MIN;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flip-flops
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign lock_pin = st_reg.lock;
  assign irq = st_reg.irq;
  assign freq_cal_start = st_reg.fstart;
  assign amp_cal_start = st_reg.astart;
  assign filt_cal_start = st_reg.tstart;
  assign temp_sensor_enable = st_reg.cfg[scl_pkg::CFG_TEMP_EN_BIT];
  assign ctrl = st_reg.ctrl;

endmodule : scl_ctrl

// [scl_ctrl_monitor.sv]
/* Concurrent checks on the ports of scl_ctrl, attached by bind.
   Assumes one pclk domain and an active-low asynchronous presetn. */
`timescale 1ns/1ps
module scl_ctrl_monitor (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // pins and engines
  input wire logic chip_enable_pin,
  input wire logic tune_in_range_pin,
  input wire logic lock_pin,
  input wire logic freq_cal_start,
  input wire logic filt_cal_start,
  input wire logic filt_cal_done,
  input wire scl_pkg::scl_ctrl_t ctrl
);
  logic r0_take; // register zero write at its taking edge
  logic byp; // bypass mode as last written
  logic chk; // tune check as last written
  logic pend; // calibration in flight, from frequency start to filter done
  assign r0_take = psel && penable && !pready && pwrite && paddr == scl_pkg::OFF_REG_ZERO;
  // mirror the lock mode bits; written at the edge where pready ends the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byp <= 1'b0;
      chk <= 1'b0;
      pend <= 1'b0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == scl_pkg::OFF_CFG) begin
        byp <= pwdata[scl_pkg::CFG_BYPASS_BIT];
        chk <= pwdata[scl_pkg::CFG_TUNE_CHK_BIT];
      end
      if (freq_cal_start) pend <= 1'b1;
      else if (filt_cal_done) pend <= 1'b0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_freq_on_write: assert property (r0_take && pwdata[0] |=> freq_cal_start)
    else $error("register zero write gave no frequency start");
  a_lock_low_start: assert property (freq_cal_start && !byp |-> !lock_pin)
    else $error("lock high at calibration start");
  a_lock_wait_cal: assert property (pend && !byp |-> !lock_pin)
    else $error("lock high before calibrations done");
  a_tune_drop: assert property (((chk || byp) && !tune_in_range_pin) [*6] |=> !lock_pin)
    else $error("lock kept while tuning out of range");
  a_bypass_tune: assert property ((byp && tune_in_range_pin && !ctrl.sleep) [*6] |=> lock_pin)
    else $error("bypass lock not following tuning");
  a_sleep_lock: assert property (ctrl.sleep [*2] |-> !lock_pin)
    else $error("lock high while asleep");
  a_ce_sleep: assert property ((!chip_enable_pin) [*6] |=> ctrl.sleep)
    else $error("chip enable low without sleep");
  a_doubler_sel: assert property (ctrl.doubler_a == (ctrl.src_a == scl_pkg::SRC_DOUBLER)
    && ctrl.doubler_b == (ctrl.src_b == scl_pkg::SRC_DOUBLER)) else $error("doubler select wrong");
  a_div_shared: assert property ((ctrl.div_log_a == scl_pkg::DIV_LOG_MAX)
    == (ctrl.div_log_b == scl_pkg::DIV_LOG_MAX)) else $error("divide by 128 not shared");
  a_div_range: assert property (ctrl.div_log_a != 3'h0 && ctrl.div_log_b != 3'h0)
    else $error("divider tap below two");
  a_seed_integer: assert property (ctrl.modulator_order == 2'h0 |-> !ctrl.seed_apply)
    else $error("seed applied in integer mode");
  a_filt_after_freq: assert property (filt_cal_start |-> pend)
    else $error("filter start outside calibration");
endmodule : scl_ctrl_monitor

bind scl_ctrl scl_ctrl_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .chip_enable_pin(chip_enable_pin), .tune_in_range_pin(tune_in_range_pin),
  .lock_pin(lock_pin), .freq_cal_start(freq_cal_start), .filt_cal_start(filt_cal_start),
  .filt_cal_done(filt_cal_done), .ctrl(ctrl));

// [scl_engine_model.sv]
/* Behavioural model of the analog calibration engines and reference tick.
   Assumes start pulses one pclk wide; slow stretches every answer. */
`timescale 1ns/1ps
module scl_engine_model #(
  parameter logic [18:0] RES = 19'h2_A5C3, // arbitrary result pattern
  parameter logic [10:0] TEMP = 11'h1F4 // arbitrary sensor code
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // starts and answer speed
  input wire logic freq_cal_start,
  input wire logic amp_cal_start,
  input wire logic filt_cal_start,
  input wire logic slow,
  // answers
  output logic freq_cal_done,
  output logic amp_cal_done,
  output logic filt_cal_done,
  output scl_pkg::scl_cal_res_t cal_res,
  output logic [10:0] temperature_code,
  output logic pd_tick
);
  logic [2:0] st; // starts, filter down to frequency
  logic [2:0] dn; // registered done pulses
  logic [5:0] cnt [3]; // time left per engine
  logic [1:0] ref_div; // reference divider to phase detector rate
  assign st = {filt_cal_start, amp_cal_start, freq_cal_start};
  assign {filt_cal_done, amp_cal_done, freq_cal_done} = dn;
  assign cal_res = RES;
  assign temperature_code = TEMP;
  // the reference runs from reset on, so it is present before any calibration
  assign pd_tick = ref_div == 2'h3;
  // each engine answers a fixed time after its start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dn <= 3'h0;
      ref_div <= 2'h0;
      for (int i = 0; i < 3; i++) cnt[i] <= 6'h00;
    end else begin
      ref_div <= ref_div + 2'h1;
      for (int i = 0; i < 3; i++) begin
        dn[i] <= cnt[i] == 6'h01;
        if (st[i]) cnt[i] <= slow ? 6'h14 : 6'h02;
        else if (cnt[i] != 6'h00) cnt[i] <= cnt[i] - 6'h01;
      end
    end
  end
endmodule : scl_engine_model

// [testbench.sv]
/* Self-checking bench for scl_ctrl with the engine model on its analog side.
   Assumes 100 MHz pclk; this module is the apb master and drives the pins. */
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic ce, tune, slow, lock, irq, fs, as, ls, fd, ad, ld, tick, tse, c0;
  scl_pkg::scl_cal_res_t res;
  logic [10:0] temp;
  scl_pkg::scl_ctrl_t ctrl;
  int err_count, comparisons, seed, nf, na, nl, ticks, t0, dl, f0, a0, l0;
  scl_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_enable_pin(ce), .tune_in_range_pin(tune), .pd_tick(tick),
    .lock_pin(lock), .irq(irq), .freq_cal_done(fd), .amp_cal_done(ad), .filt_cal_done(ld),
    .cal_res(res), .temperature_code(temp), .freq_cal_start(fs), .amp_cal_start(as),
    .filt_cal_start(ls), .temp_sensor_enable(tse), .ctrl(ctrl));
  scl_engine_model eng (.pclk(pclk), .presetn(presetn), .freq_cal_start(fs),
    .amp_cal_start(as), .filt_cal_start(ls), .slow(slow), .freq_cal_done(fd),
    .amp_cal_done(ad), .filt_cal_done(ld), .cal_res(res), .temperature_code(temp),
    .pd_tick(tick));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // tally engine starts and reference ticks; note the tick count at filter done
  always @(posedge pclk) begin
    nf <= nf + fs;
    na <= na + as;
    nl <= nl + ls;
    ticks <= ticks + tick;
    if (ld) t0 <= ticks;
  end
  task automatic test_done;
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : check
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_count++;
      test_done();
    end
  endtask : apb
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, rd);
  endtask : rd_chk
  // bounded wait for lock
  task automatic wait_lock(input int lim);
    int n;
    n = 0;
    while (lock !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      err_count++;
      test_done();
    end
  endtask : wait_lock
  // clamp zero taps, then a 128 on either side takes both
  function automatic logic [5:0] exp_div(input logic [2:0] a, input logic [2:0] b);
    if (a == 3'h0) a = 3'h1;
    if (b == 3'h0) b = 3'h1;
    if (a == 3'h7 || b == 3'h7) return 6'h3F;
    return {a, b};
  endfunction : exp_div
  // host choice of modulator order from the reduced denominator
  function automatic logic [1:0] pick_order(input int den);
    if (den > 9 && den % 3 != 0) return 2'h3;
    return 2'h2;
  endfunction : pick_order
  initial begin
    seed = 32'hb8da;
    {presetn, psel, penable, pwrite, slow} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {ce, tune} = 2'h3;
    {err_count, comparisons, nf, na, nl, ticks, t0} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("cfg reset", scl_pkg::OFF_CFG, scl_pkg::RST_CFG);
    rd_chk("out reset", scl_pkg::OFF_OUT, scl_pkg::RST_OUT);
    apb(1'b1, 8'h24, 32'hFFFF_FFFF);
    check("unmapped err", 32'h1, err_seen);
    rd_chk("unmapped read", 8'h24, 32'h0);
    apb(1'b1, scl_pkg::OFF_IRQ_MASK, 32'h1);
    // calibrations with random delay, tune check and engine speed
    for (int i = 0; i < 4; i++) begin
      dl = $random(seed) & 7;
      c0 = i[0];
      slow <= i[1];
      apb(1'b1, scl_pkg::OFF_CFG, {8'h00, dl[15:0], 7'h00, c0});
      {f0, a0, l0} = {nf, na, nl};
      apb(1'b1, scl_pkg::OFF_REG_ZERO, 32'h1);
      @(posedge pclk);
      wait_lock(900);
      check("freq starts", f0 + 1, nf);
      check("amp starts", a0 + 1, na);
      check("filt starts", l0 + 1, nl);
      check("lock delay", 1, ticks - t0 >= 4 * dl * c0 && ticks - t0 <= 4 * dl * c0 + 2);
      rd_chk("cal result", scl_pkg::OFF_CALRES, {13'h0, res});
      check("irq set", 1, irq);
      apb(1'b1, scl_pkg::OFF_IRQ_STAT, 32'h1);
      repeat (2) @(posedge pclk);
      check("irq clear", 0, irq);
    end
    // tuning replica leaves range, masked lock loss event
    tune <= 1'b0;
    repeat (10) @(posedge pclk);
    check("tune lock", 0, lock);
    tune <= 1'b1;
    rd_chk("irq status", scl_pkg::OFF_IRQ_STAT, 32'h2);
    check("irq masked", 0, irq);
    // bypassed calibration: lock follows tuning alone
    apb(1'b1, scl_pkg::OFF_CFG, 32'h4);
    apb(1'b1, scl_pkg::OFF_REG_ZERO, 32'h1);
    repeat (3) @(posedge pclk);
    check("bypass lock", 1, lock);
    repeat (100) @(posedge pclk);
    rd_chk("status", scl_pkg::OFF_STATUS, 32'h3);
    {f0, a0} = {nf, na};
    apb(1'b1, scl_pkg::OFF_REG_ZERO, 32'h0);
    repeat (30) @(posedge pclk);
    check("no freq", f0, nf);
    check("amp only", a0 + 1, na);
    // temperature readback with sensor on and off
    apb(1'b1, scl_pkg::OFF_CFG, 32'h2);
    check("sensor on", 1, tse);
    rd_chk("temp", scl_pkg::OFF_TEMP, {21'h0, temp});
    apb(1'b1, scl_pkg::OFF_CFG, 32'h0);
    rd_chk("temp off", scl_pkg::OFF_TEMP, 32'h0);
    // output taps: corners first, then random
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 32'h0 : (i == 1) ? 32'h732 : $random(seed) & 32'h77F;
      apb(1'b1, scl_pkg::OFF_OUT, d);
      repeat (2) @(posedge pclk);
      check("div taps", exp_div(d[6:4], d[10:8]), {ctrl.div_log_a, ctrl.div_log_b});
      check("doubler", {d[1:0] == 2'h2, d[3:2] == 2'h2}, {ctrl.doubler_a, ctrl.doubler_b});
    end
    // sleep bit, writes while asleep, chip enable
    apb(1'b1, scl_pkg::OFF_REG_ZERO, 32'h2);
    d = $random(seed);
    apb(1'b1, scl_pkg::OFF_SEED, d);
    check("sleep bit", 1, ctrl.sleep);
    rd_chk("seed asleep", scl_pkg::OFF_SEED, d);
    check("seed ctrl", d, ctrl.modulator_seed);
    f0 = nf;
    d = {28'h0000000, pick_order(10), 2'h1};
    apb(1'b1, scl_pkg::OFF_REG_ZERO, d);
    apb(1'b1, scl_pkg::OFF_REG_ZERO, d);
    repeat (2) @(posedge pclk);
    check("wake cals", f0 + 2, nf);
    check("awake", 0, ctrl.sleep);
    check("order", 3, ctrl.modulator_order);
    apb(1'b1, scl_pkg::OFF_REG_ZERO, 32'h0);
    @(posedge pclk);
    check("no seed", 0, ctrl.seed_apply);
    ce <= 1'b0;
    repeat (8) @(posedge pclk);
    check("ce sleep", 1, ctrl.sleep);
    test_done();
  end
endmodule : testbench
